// file: shared/pwmc_regs.svh
`ifndef PWMC_REGS_SVH
`define PWMC_REGS_SVH
// Register offsets (byte addresses, one aligned word each).
`define PWMC_MODE_OFS 8'h00
`define PWMC_DUTY_OFS 8'h04
`define PWMC_PERIOD_OFS 8'h08
`define PWMC_UPDATE_OFS 8'h0C
`define PWMC_COUNT_OFS 8'h10
`define PWMC_STATUS_OFS 8'h14
`define PWMC_MASK_OFS 8'h18
`define PWMC_ENABLE_OFS 8'h1C
`define PWMC_DIVIDER_A_FACTOR_OFS 8'h20
`define PWMC_DIVIDER_B_FACTOR_OFS 8'h24
// Mode register field positions.
`define PWMC_SRC_LSB 0
`define PWMC_SRC_MSB 3
`define PWMC_ALIGN_BIT 8
`define PWMC_POL_BIT 9
`define PWMC_UPD_BIT 10
// Clock source codes.
`define PWMC_SRC_TAP_MAX 4'hA
`define PWMC_SRC_DIVIDER_A_FACTOR 4'hB
`define PWMC_SRC_DIVIDER_B_FACTOR 4'hC
// Reset values.
`define PWMC_MODE_RST 7'h00
`define PWMC_WORD_RST 16'h0000
`define PWMC_DIV_RST 8'h00
// Widths.
`define PWMC_CNT_W 16
`define PWMC_DIV_W 8
`define PWMC_TAP_W 10
`endif

// file: shared/pwmc_pkg.sv
package pwmc_pkg;
    // Channel mode fields as held in the mode register (bits 10:8 and 3:0).
    typedef struct packed {
        logic updTarget;
        logic polarity;
        logic align;
        logic [3:0] clkSel;
    } pwmc_mode_t;
    // Counting direction of the channel counter.
    typedef enum logic [0:0] {
        PWMC_DIR_UP = 1'b0,
        PWMC_DIR_DOWN = 1'b1
    } pwmc_dir_t;
    // Register port request from the bus master.
    typedef struct packed {
        logic wrStb;
        logic rdStb;
        logic [7:0] addr;
        logic [31:0] wdata;
    } pwmc_req_t;
endpackage

// file: rtl/pwmc_clk_taps.sv
`include "pwmc_regs.svh"
module pwmc_clk_taps
    import pwmc_pkg::*;
#(
    parameter int TAP_W = `PWMC_TAP_W,
    parameter int DIV_W = `PWMC_DIV_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Source selection and divider factors.
    input wire logic [3:0] clkSel,
    input wire logic [DIV_W-1:0] divider_a_factor,
    input wire logic [DIV_W-1:0] divider_b_factor,
    // One-cycle counting enable for the channel counter.
    output logic tick
);
    // Free-running counter feeding the power-of-two taps.
    logic [TAP_W-1:0] freeCnt_q;
    // Divider counters for the two programmable clocks.
    logic [DIV_W-1:0] divCntA_q;
    logic [DIV_W-1:0] divCntB_q;
    // Per-tap ticks; tap k fires once every 2**k cycles.
    logic [TAP_W:0] tapTick;

    // The taps share one counter so that all of them stay phase related.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            freeCnt_q <= '0;
        end else begin
            freeCnt_q <= freeCnt_q + 1'b1;
        end
    end

    // Tap k fires when the low k bits of the free counter are all ones.
    assign tapTick[0] = 1'b1;
    for (genvar k = 1; k <= TAP_W; k++) begin : g_tap
        assign tapTick[k] = &freeCnt_q[k-1:0];
    end

    // Divider A wraps after its factor; a factor of zero stops it.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            divCntA_q <= '0;
        end else if (divCntA_q + 1'b1 >= divider_a_factor) begin
            divCntA_q <= '0;
        end else begin
            divCntA_q <= divCntA_q + 1'b1;
        end
    end

    // Divider B behaves exactly like divider A.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            divCntB_q <= '0;
        end else if (divCntB_q + 1'b1 >= divider_b_factor) begin
            divCntB_q <= '0;
        end else begin
            divCntB_q <= divCntB_q + 1'b1;
        end
    end

    // Source multiplexer; reserved codes give no tick, so the counter freezes.
    always_comb begin
        if (clkSel <= `PWMC_SRC_TAP_MAX) begin
            tick = tapTick[clkSel];
        end else if (clkSel == `PWMC_SRC_DIVIDER_A_FACTOR) begin
            tick = (divider_a_factor != '0) && (divCntA_q == '0);
        end else if (clkSel == `PWMC_SRC_DIVIDER_B_FACTOR) begin
            tick = (divider_b_factor != '0) && (divCntB_q == '0);
        end else begin
            tick = 1'b0;
        end
    end

    AST_RESERVED_SRC: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clkSel > `PWMC_SRC_DIVIDER_B_FACTOR) |-> !tick)
        else $error("Reserved clock source produced a tick.");

    AST_TAP_HALF: assert property (@(posedge sys_clk) disable iff (!nrst)
        (clkSel == 4'h1 && $past(clkSel) == 4'h1 && tick) |-> !$past(tick))
        else $error("Divide-by-two tap fired on two cycles in a row.");
endmodule

// file: rtl/pwmc_channel.sv
`include "pwmc_regs.svh"
module pwmc_channel
    import pwmc_pkg::*;
#(
    parameter int CNT_W = `PWMC_CNT_W,
    parameter int DIV_W = `PWMC_DIV_W
) (
    // Clock and reset.
    input wire logic sys_clk,
    input wire logic nrst,
    // Register port.
    input wire logic [7:0] regAddr,
    input wire logic [31:0] regWdata,
    input wire logic regWrStb,
    input wire logic regRdStb,
    output logic [31:0] regRdata_q,
    // Waveform and interrupt.
    output logic pwmOut_q,
    output logic irq_q
);
    // Bundled bus request.
    pwmc_req_t req;
    // Mode register.
    pwmc_mode_t mode_q;
    // Live duty and period words, plus the update buffer.
    logic [CNT_W-1:0] duty_q;
    logic [CNT_W-1:0] period_q;
    logic [CNT_W-1:0] updBuf_q;
    // Set when the update buffer holds a value not yet applied.
    logic updPend_q;
    // Channel enable and divider factors.
    logic enable_q;
    logic [DIV_W-1:0] divider_a_factor_q;
    logic [DIV_W-1:0] divider_b_factor_q;
    // Channel counter and direction.
    logic [CNT_W-1:0] cnt_q;
    pwmc_dir_t dir_q;
    // Sticky period flag and its mask.
    logic status_q;
    logic mask_q;
    // Counter enable from the source selector.
    logic tick;
    // One-cycle pulse marking the start of a new period.
    logic periodStart;
    // Incremented count, one bit wider so a wrap compare cannot overflow.
    logic [CNT_W:0] cntInc;
    // Decoded write strobes and the status read strobe.
    logic wrMode, wrDuty, wrPeriod, wrUpdate, wrEnable, wrStatus;
    logic rdStatus;

    assign req = '{wrStb: regWrStb, rdStb: regRdStb, addr: regAddr, wdata: regWdata};
    assign wrMode = req.wrStb && req.addr == `PWMC_MODE_OFS;
    assign wrDuty = req.wrStb && req.addr == `PWMC_DUTY_OFS;
    assign wrPeriod = req.wrStb && req.addr == `PWMC_PERIOD_OFS;
    assign wrUpdate = req.wrStb && req.addr == `PWMC_UPDATE_OFS;
    assign wrEnable = req.wrStb && req.addr == `PWMC_ENABLE_OFS;
    assign wrStatus = req.wrStb && req.addr == `PWMC_STATUS_OFS;
    assign rdStatus = req.rdStb && req.addr == `PWMC_STATUS_OFS;
    assign cntInc = {1'b0, cnt_q} + 1'b1;

    // Clock source selection and the two programmable dividers.
    pwmc_clk_taps #(
        .DIV_W(DIV_W)
    ) u_taps (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .clkSel(mode_q.clkSel),
        .divider_a_factor(divider_a_factor_q),
        .divider_b_factor(divider_b_factor_q),
        .tick(tick)
    );

    // A period starts at the left-mode wrap or when the center count lands on zero.
    always_comb begin
        if (!enable_q || !tick || period_q == '0) begin
            periodStart = 1'b0;
        end else if (!mode_q.align) begin
            periodStart = cntInc >= {1'b0, period_q};
        end else begin
            periodStart = dir_q == PWMC_DIR_DOWN && cnt_q <= 16'h0001;
        end
    end

    // Mode register; only bits 10:8 and 3:0 are implemented.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mode_q <= `PWMC_MODE_RST;
        end else if (wrMode) begin
            mode_q <= {regWdata[`PWMC_UPD_BIT:`PWMC_ALIGN_BIT],
                       regWdata[`PWMC_SRC_MSB:`PWMC_SRC_LSB]};
        end
    end

    // Divider factors; a zero factor leaves that divider clock stopped.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            divider_a_factor_q <= `PWMC_DIV_RST;
            divider_b_factor_q <= `PWMC_DIV_RST;
        end else if (req.wrStb && req.addr == `PWMC_DIVIDER_A_FACTOR_OFS) begin
            divider_a_factor_q <= regWdata[DIV_W-1:0];
        end else if (req.wrStb && req.addr == `PWMC_DIVIDER_B_FACTOR_OFS) begin
            divider_b_factor_q <= regWdata[DIV_W-1:0];
        end
    end

    // Update buffer; holding it back until a period start avoids glitches.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            updBuf_q <= `PWMC_WORD_RST;
            updPend_q <= 1'b0;
        end else if (wrUpdate) begin
            updBuf_q <= regWdata[CNT_W-1:0];
            updPend_q <= 1'b1;
        end else if (periodStart) begin
            updPend_q <= 1'b0;
        end
    end

    // Duty word: direct writes, or the buffered value at a period start.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            duty_q <= `PWMC_WORD_RST;
        end else if (wrDuty) begin
            duty_q <= regWdata[CNT_W-1:0];
        end else if (periodStart && updPend_q && !mode_q.updTarget) begin
            duty_q <= updBuf_q;
        end
    end

    // Period word: direct writes, or the buffered value at a period start.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            period_q <= `PWMC_WORD_RST;
        end else if (wrPeriod) begin
            period_q <= regWdata[CNT_W-1:0];
        end else if (periodStart && updPend_q && mode_q.updTarget) begin
            period_q <= updBuf_q;
        end
    end

    // Channel enable; writing bit 0 as one starts the channel.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            enable_q <= 1'b0;
        end else if (wrEnable) begin
            enable_q <= regWdata[0];
        end
    end

    // Channel counter. Left mode runs 0..period-1; center mode goes up and back.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            cnt_q <= '0;
            dir_q <= PWMC_DIR_UP;
        end else if (wrEnable || !enable_q || period_q == '0) begin
            cnt_q <= '0;
            dir_q <= PWMC_DIR_UP;
        end else if (tick) begin
            if (!mode_q.align) begin
                // Left mode: one period is period_q source ticks.
                cnt_q <= periodStart ? '0 : cntInc[CNT_W-1:0];
                dir_q <= PWMC_DIR_UP;
            end else if (dir_q == PWMC_DIR_UP) begin
                // Center mode climbs to the period value, then turns round.
                cnt_q <= cntInc[CNT_W-1:0];
                if (cntInc >= {1'b0, period_q}) begin
                    dir_q <= PWMC_DIR_DOWN;
                end
            end else begin
                // Falling half; reaching zero turns round and opens the next period.
                cnt_q <= cnt_q - 1'b1;
                if (cnt_q <= 16'h0001) begin
                    dir_q <= PWMC_DIR_UP;
                end
            end
        end
    end

    // Output: start level below the duty value, opposite level from the match.
    // The same compare gives a toggle on each direction in center mode.
    // A disabled channel rests at its start level.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            pwmOut_q <= 1'b0;
        end else if (!enable_q || cnt_q < duty_q) begin
            pwmOut_q <= mode_q.polarity;
        end else begin
            pwmOut_q <= !mode_q.polarity;
        end
    end

    // Period flag: a status read or a write of one clears it, a new period wins.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            status_q <= 1'b0;
        end else if (periodStart) begin
            status_q <= 1'b1;
        end else if (rdStatus || (wrStatus && regWdata[0])) begin
            status_q <= 1'b0;
        end
    end

    // Interrupt mask.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            mask_q <= 1'b0;
        end else if (req.wrStb && req.addr == `PWMC_MASK_OFS) begin
            mask_q <= regWdata[0];
        end
    end

    // Level interrupt, registered so the output comes from a flip-flop.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            irq_q <= 1'b0;
        end else begin
            // Follow the flag's next value, so a clear that meets a new period
            // does not drop the line for a cycle while the flag stays set.
            irq_q <= mask_q && (periodStart
                || (status_q && !rdStatus && !(wrStatus && regWdata[0])));
        end
    end

    // Read data, valid in the cycle after the read strobe and zero otherwise.
    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst) begin
            regRdata_q <= '0;
        end else if (!req.rdStb) begin
            regRdata_q <= '0;
        end else begin
            case (req.addr)
                `PWMC_MODE_OFS: regRdata_q <= {21'h000000, mode_q.updTarget,
                    mode_q.polarity, mode_q.align, 4'h0, mode_q.clkSel};
                `PWMC_DUTY_OFS: regRdata_q <= {16'h0000, duty_q};
                `PWMC_PERIOD_OFS: regRdata_q <= {16'h0000, period_q};
                `PWMC_UPDATE_OFS: regRdata_q <= {16'h0000, updBuf_q};
                `PWMC_COUNT_OFS: regRdata_q <= {16'h0000, cnt_q};
                `PWMC_STATUS_OFS: regRdata_q <= {31'h00000000, status_q};
                `PWMC_MASK_OFS: regRdata_q <= {31'h00000000, mask_q};
                `PWMC_ENABLE_OFS: regRdata_q <= {31'h00000000, enable_q};
                `PWMC_DIVIDER_A_FACTOR_OFS: regRdata_q <= {24'h000000, divider_a_factor_q};
                `PWMC_DIVIDER_B_FACTOR_OFS: regRdata_q <= {24'h000000, divider_b_factor_q};
                default: regRdata_q <= '0;
            endcase
        end
    end

    AST_LEFT_WRAP: assert property (@(posedge sys_clk) disable iff (!nrst)
        (enable_q && !mode_q.align && tick && period_q != '0
         && cntInc == {1'b0, period_q} && !wrEnable) |=> cnt_q == '0)
        else $error("Left-aligned counter did not clear at the period value.");

    AST_CENTER_TURN: assert property (@(posedge sys_clk) disable iff (!nrst)
        (enable_q && mode_q.align && tick && dir_q == PWMC_DIR_UP && !wrEnable
         && !wrPeriod && cntInc == {1'b0, period_q}) |=> dir_q == PWMC_DIR_DOWN)
        else $error("Center-aligned counter did not turn at the period value.");

    AST_START_LEVEL: assert property (@(posedge sys_clk) disable iff (!nrst)
        (enable_q && cnt_q < duty_q && !wrMode) |=> pwmOut_q == mode_q.polarity)
        else $error("Output not at starting level below the duty value.");

    AST_AFTER_MATCH: assert property (@(posedge sys_clk) disable iff (!nrst)
        (enable_q && cnt_q >= duty_q && !wrMode) |=> pwmOut_q != mode_q.polarity)
        else $error("Output did not switch level at the duty match.");

    AST_DUTY_UPDATE: assert property (@(posedge sys_clk) disable iff (!nrst)
        (periodStart && updPend_q && !mode_q.updTarget && !wrDuty && !wrUpdate)
        |=> duty_q == $past(updBuf_q))
        else $error("Buffered duty value not applied at the period start.");

    AST_PERIOD_HOLD: assert property (@(posedge sys_clk) disable iff (!nrst)
        (!periodStart && !wrPeriod) |=> period_q == $past(period_q))
        else $error("Period changed outside a period start.");

    AST_FLAG_SET: assert property (@(posedge sys_clk) disable iff (!nrst)
        periodStart |=> status_q)
        else $error("Period flag not set at the end of a period.");

    // A read that meets a new period leaves the flag set, so only lone reads must clear it.
    AST_FLAG_CLEAR: assert property (@(posedge sys_clk) disable iff (!nrst)
        (rdStatus && !periodStart) |=> !status_q)
        else $error("Period flag not cleared by a status read.");

    AST_IRQ_LEVEL: assert property (@(posedge sys_clk) disable iff (!nrst)
        (status_q && mask_q && !rdStatus && !wrStatus) |=> irq_q)
        else $error("Unmasked period flag did not raise the interrupt.");
endmodule

// file: verif/tb_top.sv
`include "pwmc_regs.svh"
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    // Clock, reset and register port driven by the bench.
    logic sys_clk;
    logic nrst;
    logic [7:0] regAddr;
    logic [31:0] regWdata;
    logic regWrStb;
    logic regRdStb;
    // Observed outputs of the channel.
    logic [31:0] rdData;
    logic pwmOut;
    logic irq;
    // Result counters and measurement results.
    int err_count;
    int cmp_count;
    int per;
    int hi;
    logic [31:0] word;

    pwmc_channel uut (
        .sys_clk(sys_clk),
        .nrst(nrst),
        .regAddr(regAddr),
        .regWdata(regWdata),
        .regWrStb(regWrStb),
        .regRdStb(regRdStb),
        .regRdata_q(rdData),
        .pwmOut_q(pwmOut),
        .irq_q(irq)
    );

    // A 4 ns clock; all sampling is done on the falling edge so it never races the design.
    always #2 sys_clk = ~sys_clk;

    // Prints the counts and the verdict, then ends the run.
    task automatic stop_test();
        $display("checks %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // Case equality, so an unknown value never passes as a match.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            $display("ERROR at %0t ns: got %h expected %h", $time, got, exp);
            err_count++;
        end
    endtask

    // A bound ran out: count it and go straight to the report.
    task automatic timeout();
        $display("ERROR at %0t ns: wait limit, got %h expected %h", $time, 1'b0, 1'b1);
        err_count++;
        stop_test();
    endtask

    // One-cycle write; the strobe is dropped at the next edge, so calls never overlap.
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regWdata <= d;
        regWrStb <= 1'b1;
        @(posedge sys_clk);
        regWrStb <= 1'b0;
    endtask

    // One-cycle read; the data stand only in the cycle after the strobe, so sample there.
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge sys_clk);
        regAddr <= a;
        regRdStb <= 1'b1;
        @(posedge sys_clk);
        regRdStb <= 1'b0;
        @(negedge sys_clk);
        d = rdData;
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] d;
        rd(a, d);
        chk(d, exp);
    endtask

    // Programs mode, duty and period, then enables, which restarts the counter.
    // Callers keep the duty value no larger than the period.
    task automatic config_ch(input logic [31:0] m, input logic [31:0] d, input logic [31:0] p);
        wr(`PWMC_MODE_OFS, m);
        wr(`PWMC_DUTY_OFS, d);
        wr(`PWMC_PERIOD_OFS, p);
        wr(`PWMC_ENABLE_OFS, 32'h00000001);
    endtask

    // Waits for a rising edge of the waveform, bounded.
    task automatic wait_rise();
        logic prev;
        prev = 1'b1;
        for (int i = 0; i < 5000; i++) begin
            @(negedge sys_clk);
            if (prev === 1'b0 && pwmOut === 1'b1) return;
            prev = pwmOut;
        end
        timeout();
    endtask

    // Cycles from one rising edge to the next, and how many of them were high.
    task automatic measure(output int p, output int h);
        logic prev;
        wait_rise();
        prev = 1'b1;
        p = 0;
        h = 1;
        for (int i = 0; i < 5000; i++) begin
            @(negedge sys_clk);
            p++;
            if (prev === 1'b0 && pwmOut === 1'b1) return;
            if (pwmOut === 1'b1) h++;
            prev = pwmOut;
        end
        timeout();
    endtask

    // Skips two cycles first; the interrupt drops at the same edge as the flag clear.
    task automatic wait_irq();
        repeat (2) @(negedge sys_clk);
        for (int i = 0; i < 1000; i++) begin
            @(negedge sys_clk);
            if (irq === 1'b1) return;
        end
        timeout();
    endtask

    // Main sequence: reset, register map, clock sources, alignment, flags, update buffer.
    initial begin
        sys_clk = 1'b0;
        nrst = 1'b0;
        regAddr = 8'h00;
        regWdata = 32'h00000000;
        regWrStb = 1'b0;
        regRdStb = 1'b0;
        err_count = 0;
        cmp_count = 0;
        repeat (5) @(posedge sys_clk);
        nrst <= 1'b1;
        @(negedge sys_clk);
        chk({31'h0, pwmOut}, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        for (int a = 0; a <= 8'h24; a += 4) begin
            rd_chk(8'(a), 32'h00000000);
        end
        rd_chk(8'h30, 32'h00000000);
        $display("test reset_values done");

        // Only the documented mode bits and the low 16 bits of duty and period are kept.
        wr(`PWMC_MODE_OFS, 32'hFFFFFFFF);
        rd_chk(`PWMC_MODE_OFS, 32'h0000070F);
        wr(`PWMC_DUTY_OFS, 32'hABCD1234);
        rd_chk(`PWMC_DUTY_OFS, 32'h00001234);
        wr(`PWMC_PERIOD_OFS, 32'h5678ABCD);
        rd_chk(`PWMC_PERIOD_OFS, 32'h0000ABCD);
        wr(8'h30, 32'hFFFFFFFF);
        rd_chk(8'h30, 32'h00000000);
        wr(`PWMC_COUNT_OFS, 32'h0000FFFF);
        rd_chk(`PWMC_COUNT_OFS, 32'h00000000);
        chk({31'h0, pwmOut}, 32'h00000001);
        $display("test register_map done");

        // Every prescaler tap: left period is divisor times period, high for the tail, or for the head with polarity set.
        for (int code = 0; code <= 10; code++) begin
            config_ch(32'(code), 32'h00000001, 32'h00000002);
            measure(per, hi);
            chk(32'(per), 32'(2 << code));
            chk(32'(hi), 32'(1 << code));
        end
        config_ch(32'h00000200, 32'h00000003, 32'h00000008);
        measure(per, hi);
        chk(32'(per), 32'h00000008);
        chk(32'(hi), 32'h00000003);
        $display("test prescaler_left done");

        // Center alignment doubles the period on a tap and on divider A; divider B runs left aligned only.
        config_ch(32'h00000100, 32'h00000001, 32'h00000004);
        measure(per, hi);
        chk(32'(per), 32'h00000008);
        config_ch(32'h00000102, 32'h00000001, 32'h00000004);
        measure(per, hi);
        chk(32'(per), 32'h00000020);
        wr(`PWMC_DIVIDER_A_FACTOR_OFS, 32'h00000003);
        wr(`PWMC_DIVIDER_B_FACTOR_OFS, 32'h00000005);
        config_ch(32'h0000000B, 32'h00000001, 32'h00000004);
        measure(per, hi);
        chk(32'(per), 32'h0000000C);
        chk(32'(hi), 32'h00000009);
        config_ch(32'h0000000C, 32'h00000001, 32'h00000004);
        measure(per, hi);
        chk(32'(per), 32'h00000014);
        config_ch(32'h0000010B, 32'h00000001, 32'h00000004);
        measure(per, hi);
        chk(32'(per), 32'h00000018);
        // A reserved source code gives no ticks, so the restarted counter stays at zero.
        config_ch(32'h0000000E, 32'h00000001, 32'h00000004);
        repeat (20) @(negedge sys_clk);
        rd_chk(`PWMC_COUNT_OFS, 32'h00000000);
        $display("test center_and_dividers done");

        // Re-enabling restarts the counter from zero.
        config_ch(32'h00000000, 32'h0000000A, 32'h000003E8);
        repeat (300) @(negedge sys_clk);
        rd(`PWMC_COUNT_OFS, word);
        chk({31'h0, word > 32'd200}, 32'h00000001);
        wr(`PWMC_ENABLE_OFS, 32'h00000001);
        rd(`PWMC_COUNT_OFS, word);
        chk({31'h0, word < 32'd8}, 32'h00000001);
        $display("test counter_restart done");

        // Period flag: set each period, cleared by a read or by writing a one.
        wr(`PWMC_MASK_OFS, 32'h00000001);
        config_ch(32'h00000000, 32'h00000032, 32'h00000064);
        rd(`PWMC_STATUS_OFS, word);
        wait_irq();
        rd_chk(`PWMC_STATUS_OFS, 32'h00000001);
        rd_chk(`PWMC_STATUS_OFS, 32'h00000000);
        chk({31'h0, irq}, 32'h00000000);
        wait_irq();
        wr(`PWMC_STATUS_OFS, 32'h00000001);
        rd_chk(`PWMC_STATUS_OFS, 32'h00000000);
        wr(`PWMC_MASK_OFS, 32'h00000000);
        repeat (250) @(negedge sys_clk);
        chk({31'h0, irq}, 32'h00000000);
        rd_chk(`PWMC_STATUS_OFS, 32'h00000001);
        $display("test period_flag done");

        // Update buffer: right after a period start, so the next start is far away.
        wr(`PWMC_MASK_OFS, 32'h00000001);
        wait_irq();
        rd(`PWMC_STATUS_OFS, word);
        wr(`PWMC_UPDATE_OFS, 32'h0000001E);
        rd_chk(`PWMC_DUTY_OFS, 32'h00000032);
        wait_irq();
        rd(`PWMC_STATUS_OFS, word);
        rd_chk(`PWMC_DUTY_OFS, 32'h0000001E);
        wr(`PWMC_MODE_OFS, 32'h00000400);
        wait_irq();
        rd(`PWMC_STATUS_OFS, word);
        wr(`PWMC_UPDATE_OFS, 32'h00000078);
        rd_chk(`PWMC_PERIOD_OFS, 32'h00000064);
        wait_irq();
        rd_chk(`PWMC_PERIOD_OFS, 32'h00000078);
        rd_chk(`PWMC_DUTY_OFS, 32'h0000001E);
        $display("test update_buffer done");
        stop_test();
    end
endmodule
